// file: verilog/codec_conversion_timing_gen.sv
// Timing generator, serial link and registers of the codec.
// Assumes CLK is the master clock; AXI4-Lite master and serial host share it.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module codec_conversion_timing_gen (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        SYNC_MODE,
    input  wire logic        SERIAL_IN_FROM_HOST,
    output logic             SERIAL_OUT_TO_HOST,
    output logic             SHIFT_CLOCK,
    output logic             TX_FRAME_SYNC_N,
    output logic             RX_FRAME_SYNC_N,
    output logic             TX_FILTER_CLOCK,
    output logic             RX_FILTER_CLOCK,
    output logic             TX_CONVERT,
    output logic             RX_CONVERT,
    output logic             ANALOG_LOOPBACK,
    output logic [15:0]      DAC_WORD,
    input  wire logic [15:0] ADC_WORD
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [5:0] load_a(input logic [5:0] base, input logic [5:0] adj,
                                          input logic [1:0] sel);
        logic [5:0] sum;
        sum = base;
        if (sel == codec_timing_pkg::SEL_MINUS) begin
            sum = base - adj;
        end else if (sel == codec_timing_pkg::SEL_PLUS) begin
            sum = base + adj;
        end
        if (sum <= codec_timing_pkg::LOAD_MIN) begin
            sum = base; // RQ18
        end
        return sum;
    endfunction : load_a

    function automatic logic [5:0] b_guard(input logic [5:0] v);
        return (v <= codec_timing_pkg::LOAD_MIN) ? codec_timing_pkg::B_FALLBACK : v; // RQ19
    endfunction : b_guard

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : merge

    // ****************************************
    // Register bus
    // ****************************************
    logic [5:0]  tx_a_q, tx_a_d, tx_adj_q, tx_adj_d, tx_b_q, tx_b_d;
    logic [5:0]  rx_a_q, rx_a_d, rx_adj_q, rx_adj_d, rx_b_q, rx_b_d;
    logic [15:0] ctrl_q, ctrl_d, wr_val, sec_word_q, dac_q;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d, wr_go, rd_go;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    assign wr_go   = CE && AWVALID && WVALID && !bvalid_q;
    assign rd_go   = CE && ARVALID && !rvalid_q;
    assign AWREADY = wr_go;
    assign WREADY  = wr_go;
    assign ARREADY = rd_go;

    always_comb begin
        tx_a_d   = tx_a_q;
        tx_adj_d = tx_adj_q;
        tx_b_d   = tx_b_q;
        rx_a_d   = rx_a_q;
        rx_adj_d = rx_adj_q;
        rx_b_d   = rx_b_q;
        ctrl_d   = ctrl_q;
        bvalid_d = bvalid_q && !(CE && BREADY);
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q && !(CE && RREADY);
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        wr_val   = merge({10'h000, tx_a_q}, WDATA, WSTRB);
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d  = codec_timing_pkg::RESP_OKAY;
            if (AWADDR == codec_timing_pkg::OFF_TX_A) begin
                tx_a_d = wr_val[5:0];
            end else if (AWADDR == codec_timing_pkg::OFF_TX_ADJ) begin
                wr_val   = merge({10'h000, tx_adj_q}, WDATA, WSTRB);
                tx_adj_d = wr_val[5:0];
            end else if (AWADDR == codec_timing_pkg::OFF_TX_B) begin
                wr_val = merge({10'h000, tx_b_q}, WDATA, WSTRB);
                tx_b_d = b_guard(wr_val[5:0]); // RQ19
            end else if (AWADDR == codec_timing_pkg::OFF_RX_A) begin
                wr_val = merge({10'h000, rx_a_q}, WDATA, WSTRB);
                rx_a_d = wr_val[5:0];
            end else if (AWADDR == codec_timing_pkg::OFF_RX_ADJ) begin
                wr_val   = merge({10'h000, rx_adj_q}, WDATA, WSTRB);
                rx_adj_d = wr_val[5:0];
            end else if (AWADDR == codec_timing_pkg::OFF_RX_B) begin
                wr_val = merge({10'h000, rx_b_q}, WDATA, WSTRB);
                rx_b_d = b_guard(wr_val[5:0]); // RQ19
            end else if (AWADDR == codec_timing_pkg::OFF_CTRL) begin
                wr_val = merge(ctrl_q, WDATA, WSTRB);
                ctrl_d = {6'h00, wr_val[9:2], 2'h0};
            end else begin
                bresp_d = codec_timing_pkg::RESP_SLVERR;
            end
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = codec_timing_pkg::RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            if (ARADDR == codec_timing_pkg::OFF_TX_A) begin
                rdata_d[5:0] = tx_a_q;
            end else if (ARADDR == codec_timing_pkg::OFF_TX_ADJ) begin
                rdata_d[5:0] = tx_adj_q;
            end else if (ARADDR == codec_timing_pkg::OFF_TX_B) begin
                rdata_d[5:0] = tx_b_q;
            end else if (ARADDR == codec_timing_pkg::OFF_RX_A) begin
                rdata_d[5:0] = rx_a_q;
            end else if (ARADDR == codec_timing_pkg::OFF_RX_ADJ) begin
                rdata_d[5:0] = rx_adj_q;
            end else if (ARADDR == codec_timing_pkg::OFF_RX_B) begin
                rdata_d[5:0] = rx_b_q;
            end else if (ARADDR == codec_timing_pkg::OFF_CTRL) begin
                rdata_d[15:0] = ctrl_q;
            end else if (ARADDR == codec_timing_pkg::OFF_SEC_WORD) begin
                rdata_d[15:0] = sec_word_q;
            end else if (ARADDR == codec_timing_pkg::OFF_DAC_WORD) begin
                rdata_d[15:0] = dac_q;
            end else begin
                rresp_d = codec_timing_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_a_q   <= codec_timing_pkg::RST_A; // RQ14
            tx_adj_q <= codec_timing_pkg::RST_ADJ;
            tx_b_q   <= codec_timing_pkg::RST_B;
            rx_a_q   <= codec_timing_pkg::RST_A;
            rx_adj_q <= codec_timing_pkg::RST_ADJ;
            rx_b_q   <= codec_timing_pkg::RST_B;
            ctrl_q   <= codec_timing_pkg::RST_CTRL; // RQ15
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q  <= 2'h0;
            rdata_q  <= 32'h0000_0000;
        end else if (CE) begin
            tx_a_q   <= tx_a_d;
            tx_adj_q <= tx_adj_d;
            tx_b_q   <= tx_b_d;
            rx_a_q   <= rx_a_d;
            rx_adj_q <= rx_adj_d;
            rx_b_q   <= rx_b_d;
            ctrl_q   <= ctrl_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
        end
    end

    assign BVALID = bvalid_q;
    assign BRESP  = bresp_q;
    assign RVALID = rvalid_q;
    assign RRESP  = rresp_q;
    assign RDATA  = rdata_q;

    // ****************************************
    // Divider pairs
    // ****************************************
    logic [5:0] tx_ca_q, tx_ca_d, tx_cb_q, tx_cb_d, rx_ca_q, rx_ca_d, rx_cb_q, rx_cb_d;
    logic       tx_fc_q, tx_fc_d, rx_fc_q, rx_fc_d, tx_cv_q, rx_cv_q;
    logic [1:0] tx_sel_q, tx_sel_d, rx_sel_q, rx_sel_d, adj_req;
    logic       tx_a_term, tx_b_term, rx_a_term, rx_b_term, adj_set;

    assign tx_a_term = tx_ca_q <= codec_timing_pkg::LOAD_MIN; // RQ21
    assign tx_b_term = tx_a_term && tx_fc_q && tx_cb_q <= codec_timing_pkg::LOAD_MIN;
    assign rx_a_term = rx_ca_q <= codec_timing_pkg::LOAD_MIN;
    assign rx_b_term = rx_a_term && rx_fc_q && rx_cb_q <= codec_timing_pkg::LOAD_MIN;

    always_comb begin
        tx_ca_d  = tx_a_term ? tx_a_q : tx_ca_q - 6'h01; // RQ2
        tx_fc_d  = tx_fc_q ^ tx_a_term;
        tx_cb_d  = (tx_a_term && tx_fc_q) ? tx_cb_q - 6'h01 : tx_cb_q; // RQ3
        tx_sel_d = tx_sel_q;
        rx_ca_d  = rx_a_term ? rx_a_q : rx_ca_q - 6'h01;
        rx_fc_d  = rx_fc_q ^ rx_a_term;
        rx_cb_d  = (rx_a_term && rx_fc_q) ? rx_cb_q - 6'h01 : rx_cb_q;
        rx_sel_d = rx_sel_q;
        if (tx_b_term) begin
            tx_ca_d  = load_a(tx_a_q, tx_adj_q, tx_sel_q); // RQ4 RQ5 RQ6
            tx_cb_d  = tx_b_q;
            tx_sel_d = codec_timing_pkg::SEL_PLAIN;
        end
        if (rx_b_term) begin
            rx_ca_d  = load_a(rx_a_q, rx_adj_q, rx_sel_q); // RQ4 RQ7
            rx_cb_d  = rx_b_q;
            rx_sel_d = codec_timing_pkg::SEL_PLAIN;
        end
        if (adj_set) begin
            tx_sel_d = adj_req;
            rx_sel_d = adj_req;
        end
        if (SYNC_MODE) begin
            rx_ca_d = rx_ca_q; // RQ9
            rx_cb_d = rx_cb_q;
            rx_fc_d = rx_fc_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_ca_q  <= codec_timing_pkg::RST_A;
            tx_cb_q  <= codec_timing_pkg::RST_B;
            tx_fc_q  <= 1'b0;
            tx_sel_q <= codec_timing_pkg::SEL_PLAIN;
            tx_cv_q  <= 1'b0;
            rx_ca_q  <= codec_timing_pkg::RST_A;
            rx_cb_q  <= codec_timing_pkg::RST_B;
            rx_fc_q  <= 1'b0;
            rx_sel_q <= codec_timing_pkg::SEL_PLAIN;
            rx_cv_q  <= 1'b0;
        end else if (CE) begin
            tx_ca_q  <= tx_ca_d;
            tx_cb_q  <= tx_cb_d;
            tx_fc_q  <= tx_fc_d;
            tx_sel_q <= tx_sel_d;
            tx_cv_q  <= tx_b_term;
            rx_ca_q  <= rx_ca_d;
            rx_cb_q  <= rx_cb_d;
            rx_fc_q  <= rx_fc_d;
            rx_sel_q <= rx_sel_d;
            rx_cv_q  <= SYNC_MODE ? tx_b_term : rx_b_term; // RQ8 RQ20
        end
    end

    assign TX_FILTER_CLOCK = tx_fc_q;
    assign RX_FILTER_CLOCK = SYNC_MODE ? tx_fc_q : rx_fc_q; // RQ8
    assign TX_CONVERT      = tx_cv_q;
    assign RX_CONVERT      = rx_cv_q;

    // ****************************************
    // Serial link
    // ****************************************
    codec_timing_pkg::link_state_e st_q, st_d;
    logic [1:0]  div_q;
    logic [3:0]  bit_q, bit_d;
    logic [15:0] in_sr_q, in_sr_d, out_sr_q, out_sr_d, adc_q, adc_d, sec_d, dac_d;
    logic        tx_pend_q, tx_pend_d, rx_pend_q, rx_pend_d, rx_fs_q, rx_fs_d, shift_end;

    assign shift_end = div_q == codec_timing_pkg::DIV_LAST;
    assign adj_req   = in_sr_d[1:0];

    always_comb begin
        st_d      = st_q;
        bit_d     = bit_q;
        in_sr_d   = in_sr_q;
        out_sr_d  = out_sr_q;
        sec_d     = sec_word_q;
        dac_d     = dac_q;
        rx_fs_d   = rx_fs_q;
        adj_set   = 1'b0;
        tx_pend_d = tx_pend_q || tx_b_term;
        rx_pend_d = rx_pend_q || (SYNC_MODE ? tx_b_term : rx_b_term);
        adc_d     = adc_q;
        if (SYNC_MODE ? tx_b_term : rx_b_term) begin
            adc_d = ctrl_q[codec_timing_pkg::CTRL_LOOPBACK] ?
                    {dac_q[15:2], 2'h0} : ADC_WORD; // RQ16
        end
        if (div_q == codec_timing_pkg::DIV_SAMPLE && st_q != codec_timing_pkg::LINK_IDLE
                && st_q != codec_timing_pkg::LINK_GAP) begin
            in_sr_d = {in_sr_q[14:0], SERIAL_IN_FROM_HOST};
        end
        if (shift_end) begin
            case (st_q)
                codec_timing_pkg::LINK_IDLE: begin
                    if (tx_pend_q) begin
                        st_d      = codec_timing_pkg::LINK_PRIMARY;
                        bit_d     = 4'h0;
                        tx_pend_d = tx_b_term;
                        rx_fs_d   = rx_pend_q;
                        rx_pend_d = 1'b0;
                        out_sr_d  = rx_pend_q ? adc_q : 16'h0000;
                    end
                end
                codec_timing_pkg::LINK_PRIMARY: begin
                    bit_d    = bit_q + 4'h1;
                    out_sr_d = {out_sr_q[14:0], 1'b0};
                    if (bit_q == codec_timing_pkg::WORD_LAST) begin
                        dac_d   = in_sr_q;
                        rx_fs_d = 1'b0;
                        bit_d   = 4'h0;
                        if (in_sr_q[1:0] == codec_timing_pkg::SEC_REQUEST) begin
                            st_d = codec_timing_pkg::LINK_GAP; // RQ10
                        end else begin
                            st_d    = codec_timing_pkg::LINK_IDLE;
                            adj_set = 1'b1;
                        end
                    end
                end
                codec_timing_pkg::LINK_GAP: begin
                    bit_d = bit_q + 4'h1;
                    if (bit_q == codec_timing_pkg::GAP_LAST) begin
                        st_d  = codec_timing_pkg::LINK_SECONDARY; // RQ11
                        bit_d = 4'h0;
                    end
                end
                default: begin
                    bit_d    = bit_q + 4'h1;
                    out_sr_d = {out_sr_q[14:0], 1'b0};
                    if (bit_q == codec_timing_pkg::WORD_LAST) begin
                        sec_d = in_sr_q; // RQ12
                        st_d  = codec_timing_pkg::LINK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q       <= codec_timing_pkg::LINK_IDLE;
            div_q      <= 2'h0;
            bit_q      <= 4'h0;
            in_sr_q    <= 16'h0000;
            out_sr_q   <= 16'h0000;
            sec_word_q <= 16'h0000;
            dac_q      <= 16'h0000;
            adc_q      <= 16'h0000;
            tx_pend_q  <= 1'b0;
            rx_pend_q  <= 1'b0;
            rx_fs_q    <= 1'b0;
        end else if (CE) begin
            st_q       <= st_d;
            div_q      <= div_q + 2'h1; // RQ1
            bit_q      <= bit_d;
            in_sr_q    <= in_sr_d;
            out_sr_q   <= out_sr_d;
            sec_word_q <= sec_d;
            dac_q      <= dac_d;
            adc_q      <= adc_d;
            tx_pend_q  <= tx_pend_d;
            rx_pend_q  <= rx_pend_d;
            rx_fs_q    <= rx_fs_d;
        end
    end

    assign SHIFT_CLOCK        = div_q[1];
    assign SERIAL_OUT_TO_HOST = out_sr_q[15];
    assign TX_FRAME_SYNC_N    = !(st_q == codec_timing_pkg::LINK_PRIMARY
                                  || st_q == codec_timing_pkg::LINK_SECONDARY);
    assign RX_FRAME_SYNC_N    = !(rx_fs_q && st_q == codec_timing_pkg::LINK_PRIMARY); // RQ13
    assign ANALOG_LOOPBACK    = ctrl_q[codec_timing_pkg::CTRL_LOOPBACK];
    assign DAC_WORD           = dac_q;

    // ****************************************
    // Checks
    // ****************************************
    sequence gap_done_s;
        CE && st_q == codec_timing_pkg::LINK_GAP && bit_q == codec_timing_pkg::GAP_LAST
            && shift_end;
    endsequence

    a_shift_div: assert property (@(posedge CLK) disable iff (RST)
        $rose(SHIFT_CLOCK) |-> $past(div_q) == 2'h1) else $error("shift clock off"); // RQ1
    a_b_reload: assert property (@(posedge CLK) disable iff (RST)
        CE && tx_b_term |=> tx_cb_q == tx_b_q && TX_CONVERT) else $error("b reload"); // RQ3
    a_minus_load: assert property (@(posedge CLK) disable iff (RST)
        CE && tx_b_term && tx_sel_q == codec_timing_pkg::SEL_MINUS && tx_a_q - tx_adj_q > 6'h01
        |=> tx_ca_q == $past(tx_a_q) - $past(tx_adj_q)) else $error("minus load"); // RQ6
    a_adj_fallback: assert property (@(posedge CLK) disable iff (RST)
        CE && tx_b_term && tx_sel_q == codec_timing_pkg::SEL_PLUS && tx_a_q + tx_adj_q <= 6'h01
        |=> tx_ca_q == $past(tx_a_q)) else $error("fallback load"); // RQ18
    a_b_guard: assert property (@(posedge CLK) disable iff (RST)
        wr_go && AWADDR == codec_timing_pkg::OFF_TX_B && WSTRB[0] && WDATA[5:0] <= 6'h01
        |=> tx_b_q == codec_timing_pkg::B_FALLBACK) else $error("b guard"); // RQ19
    a_reset_values: assert property (@(posedge CLK) disable iff (RST)
        $past(RST) |-> tx_a_q == 6'h09 && rx_adj_q == 6'h01 && rx_b_q == 6'h24
        && ctrl_q == 16'h02e4) else $error("reset values"); // RQ14
    a_gap_high: assert property (@(posedge CLK) disable iff (RST)
        st_q == codec_timing_pkg::LINK_GAP |-> TX_FRAME_SYNC_N
        && bit_q <= codec_timing_pkg::GAP_LAST) else $error("gap sync"); // RQ11
    a_gap_end: assert property (@(posedge CLK) disable iff (RST)
        gap_done_s |=> !TX_FRAME_SYNC_N && bit_q == 4'h0) else $error("gap end"); // RQ11
    a_sync_rx_quiet: assert property (@(posedge CLK) disable iff (RST)
        SYNC_MODE && st_q == codec_timing_pkg::LINK_SECONDARY |-> RX_FRAME_SYNC_N)
        else $error("rx sync in secondary"); // RQ13
    a_sync_follow: assert property (@(posedge CLK) disable iff (RST)
        SYNC_MODE && $past(SYNC_MODE) |-> RX_CONVERT == TX_CONVERT
        && RX_FILTER_CLOCK == TX_FILTER_CLOCK) else $error("sync follow"); // RQ8

endmodule : codec_conversion_timing_gen

// file: verilog/codec_timing_pkg.sv
// Constants, register map and state types for the codec conversion timing generator.
// Assumes a single master clock with a clock enable and AXI4-Lite register access.
// How it works
// (RQ1) Shift clock is the master clock divided by four.
// (RQ2) Filter clock equals master clock over twice the counter A contents, per path.
// (RQ3) Conversion strobe is filter clock over counter B, loaded from its B register.
// (RQ4) Both counters of a path reload once every conversion period of that path.
// (RQ5) Transmit counter A loads A, A minus adjust, or A plus adjust by selection.
// (RQ6) Minus option advances, plus option retards, the next conversion by adjust ticks.
// (RQ7) Receive counter A offers the same three load choices from receive registers.
// (RQ8) Synchronous mode derives both filter clocks and conversions from transmit counters.
// (RQ9) Synchronous mode ignores receive counters and receive A, adjust and B registers.
// (RQ10) Primary word with both low bits set starts a secondary transfer afterwards.
// (RQ11) After the primary, transmit frame sync stays high four shift clocks, then falls.
// (RQ12) Secondary uses primary timing and sits between primaries, no DAC output skipped.
// (RQ13) Synchronous mode keeps receive frame sync idle during secondary transfers.
// (RQ14) Reset loads A registers with 9, adjust registers with 1, B registers with 36.
// (RQ15) Reset sets control bits 9, 7, 6, 5, 2 and clears bits 4 and 3.
// (RQ16) Loopback returns transmitted DAC bits 15 to 2 as the received ADC bits.
// (RQ17) Host picks master clock and A values giving a 288 kHz filter clock.
// (RQ18) A plus or minus adjust equal to 0 or 1 loads plain A instead.
// (RQ19) A B register written with 0 or 1 takes 36 instead.
// (RQ20) Synchronous receive conversion equals transmit conversion, chosen by a mode pin.
// (RQ21) Counters count down ticks, a one-cycle terminal pulse reloads and advances.
package codec_timing_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  OFF_TX_A      = 8'h00;
    localparam logic [7:0]  OFF_TX_ADJ    = 8'h04;
    localparam logic [7:0]  OFF_TX_B      = 8'h08;
    localparam logic [7:0]  OFF_RX_A      = 8'h0c;
    localparam logic [7:0]  OFF_RX_ADJ    = 8'h10;
    localparam logic [7:0]  OFF_RX_B      = 8'h14;
    localparam logic [7:0]  OFF_CTRL      = 8'h18;
    localparam logic [7:0]  OFF_SEC_WORD  = 8'h1c;
    localparam logic [7:0]  OFF_DAC_WORD  = 8'h20;

    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [5:0]  RST_A         = 6'h09;
    localparam logic [5:0]  RST_ADJ       = 6'h01;
    localparam logic [5:0]  RST_B         = 6'h24;
    localparam logic [5:0]  B_FALLBACK    = 6'h24;
    localparam logic [15:0] RST_CTRL      = 16'h02e4;
    localparam int unsigned CTRL_LOOPBACK = 3;
    localparam logic [5:0]  LOAD_MIN      = 6'h01;

    // ****************************************
    // Link timing, adjust selections and bus responses
    // ****************************************
    localparam logic [1:0]  DIV_SAMPLE    = 2'h1;
    localparam logic [1:0]  DIV_LAST      = 2'h3;
    localparam logic [3:0]  WORD_LAST     = 4'hf;
    localparam logic [3:0]  GAP_LAST      = 4'h3;
    localparam logic [1:0]  SEC_REQUEST   = 2'h3;
    localparam logic [1:0]  SEL_MINUS     = 2'h1;
    localparam logic [1:0]  SEL_PLUS      = 2'h2;
    localparam logic [1:0]  SEL_PLAIN     = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {LINK_IDLE, LINK_PRIMARY, LINK_GAP, LINK_SECONDARY} link_state_e;

endpackage : codec_timing_pkg

// file: dv/dsp_host.sv
// Serial host model: shifts a word MSB first while transmit frame sync is low.
// Assumes shift clock and frame sync come from the codec on the master clock.
`timescale 1ns/1ps
module dsp_host (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        SHIFT_CLOCK,
    input  wire logic        TX_FRAME_SYNC_N,
    input  wire logic [15:0] prim,
    input  wire logic [15:0] sec,
    input  wire logic        RX_FRAME_SYNC_N,
    input  wire logic        SERIAL_OUT_TO_HOST,
    output logic             SERIAL_IN_FROM_HOST
);
    logic [3:0]  cnt_q;
    logic        sck_q, fs_q, sec_q, last_q, rfs_q;
    logic [15:0] rx_sr_q, rx_word_q;
    wire  [15:0] w = sec_q ? sec : prim;
    // Released line shows the inverse of the last bit
    assign SERIAL_IN_FROM_HOST = TX_FRAME_SYNC_N ? ~last_q : w[~cnt_q];
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {cnt_q, sck_q, sec_q, last_q, rx_sr_q, rx_word_q} <= '0;
            {fs_q, rfs_q} <= 2'h3;
        end else begin
            sck_q <= SHIFT_CLOCK;
            fs_q <= TX_FRAME_SYNC_N;
            rfs_q <= RX_FRAME_SYNC_N;
            // Received word is taken on shift clock rise, kept when receive sync ends
            if (!RX_FRAME_SYNC_N && SHIFT_CLOCK && !sck_q)
                rx_sr_q <= {rx_sr_q[14:0], SERIAL_OUT_TO_HOST};
            if (RX_FRAME_SYNC_N && !rfs_q) rx_word_q <= rx_sr_q;
            if (!TX_FRAME_SYNC_N) last_q <= SERIAL_IN_FROM_HOST;
            if (TX_FRAME_SYNC_N) cnt_q <= '0;
            else if (SHIFT_CLOCK && !sck_q) cnt_q <= cnt_q + 4'h1;
            if (TX_FRAME_SYNC_N && !fs_q) sec_q <= !sec_q && prim[1:0] == 2'h3;
        end
    end
endmodule : dsp_host

// file: dv/testbench.sv
// Self-checking bench for the codec timing generator with a serial host model.
// Assumes a 10 MHz master clock and the register map of the design package.
`timescale 1ns/1ps
module testbench;
    logic        CLK, RST, CE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID;
    logic        ARREADY, RVALID, RREADY, SYNC_MODE, SERIAL_IN_FROM_HOST, SERIAL_OUT_TO_HOST;
    logic        SHIFT_CLOCK, TX_FRAME_SYNC_N, RX_FRAME_SYNC_N, TX_FILTER_CLOCK, RX_FILTER_CLOCK;
    logic        TX_CONVERT, RX_CONVERT, ANALOG_LOOPBACK, fq;
    logic [1:0]  BRESP, RRESP;
    logic [3:0]  WSTRB;
    logic [4:0]  mq;
    logic [5:0]  v;
    logic [7:0]  AWADDR, ARADDR;
    logic [15:0] DAC_WORD, ADC_WORD, prim, sec;
    logic [31:0] WDATA, RDATA;
    logic [33:0] expq [$];
    logic [33:0] rst_val [7] = '{34'h9, 34'h1, 34'h24, 34'h9, 34'h1, 34'h24, 34'h2e4};
    int          n_mismatch, checks, seed, cyc, rise, gap, bad, pr [5], tl [5], mn = 99;
    int          exp_p [5] = '{4, 10, 40, 10, 40};
    wire  [4:0]  mv = {RX_CONVERT, RX_FILTER_CLOCK, TX_CONVERT, TX_FILTER_CLOCK, SHIFT_CLOCK};

    codec_conversion_timing_gen codec_conversion_timing_gen_i (.*);
    dsp_host dsp_host_i (.*);

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic wt(input int k);
        int n;
        n = 0;
        #1;
        while (!(k == 1 ? AWREADY : k == 2 ? BVALID : k == 3 ? ARREADY : RVALID) && n++ < 999)
            @(posedge CLK) #1;
        if (n > 999) n_mismatch++;
        @(posedge CLK);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'h7};
        wt(1);
        {AWVALID, WVALID} <= 2'h0;
        wt(2);
        chk("bresp", 34'h0, BRESP);
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        wt(3);
        ARVALID <= 1'b0;
        wt(4);
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask : rd
    task automatic conclude;
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    always @(posedge CLK) if (RVALID && RREADY) chk("read", expq.pop_front(), {RRESP, RDATA});
    always @(posedge CLK) ADC_WORD <= 16'($random(seed));
    always @(negedge CLK) begin
        for (int i = 0; i < 5; i++)
            if (mv[i] && !mq[i]) begin
                pr[i] = cyc - tl[i];
                tl[i] = cyc;
                if (i == 2 && pr[i] < mn) mn = pr[i];
            end
        if (TX_FRAME_SYNC_N && !fq) rise = cyc;
        if (!TX_FRAME_SYNC_N && fq && dsp_host_i.sec_q) gap = cyc - rise;
        if (!TX_FRAME_SYNC_N && dsp_host_i.sec_q && SYNC_MODE && !RX_FRAME_SYNC_N) bad++;
        mq = mv;
        fq = TX_FRAME_SYNC_N;
        cyc++;
    end
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        conclude();
    end
    initial begin
        seed = 28;
        {CE, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, SYNC_MODE} = 8'hc0;
        {AWADDR, ARADDR, WDATA, WSTRB} = {48'h0, 4'h3};
        prim = 16'ha5a4;
        sec = 16'h1234;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        foreach (rst_val[i]) rd(8'(4 * i), rst_val[i]);
        rd(8'h40, {2'h2, 32'h0});
        for (int i = 0; i < 4; i++) begin
            wr(i[1] ? 8'h14 : 8'h08, 32'(i[0]));
            rd(i[1] ? 8'h14 : 8'h08, 34'h24);
        end
        v = 6'($random(seed)) | 6'h8;
        wr(8'h0c, 32'(v));
        rd(8'h0c, 34'(v));
        wr(8'h18, 32'h2ec);
        rd(8'h18, 34'h2ec);
        chk("loopback", 34'h1, ANALOG_LOOPBACK);
        wr(8'h00, 32'h5);
        wr(8'h08, 32'h4);
        SYNC_MODE <= 1'b1;
        prim <= 16'ha5a7;
        repeat (700) @(posedge CLK);
        foreach (exp_p[i]) chk("period", exp_p[i], pr[i]);
        chk("gap", 34'd16, gap);
        chk("rx sync", 34'h0, bad);
        rd(8'h1c, 34'h1234);
        chk("dac", 34'ha5a7, DAC_WORD);
        chk("loop word", 34'ha5a4, dsp_host_i.rx_word_q);
        prim <= 16'ha5a5;
        repeat (300) @(posedge CLK);
        chk("advance", 34'd39, mn);
        conclude();
    end
endmodule : testbench
